// File: verilog/lane_test_pattern_regs.vh
`ifndef LANE_TEST_PATTERN_REGS_VH
`define LANE_TEST_PATTERN_REGS_VH
// Register indexes; byte address is four times the index
`define IDX_LANE_CTRL        8'h15
`define IDX_LANE34_PAT       8'h17
`define IDX_LANE_MISC        8'h18
`define IDX_FILTER_STATUS    8'h19
`define ADDR_LANE_CTRL       12'h054
`define ADDR_LANE34_PAT      12'h05c
`define ADDR_LANE_MISC       12'h060
`define ADDR_FILTER_STATUS   12'h064
// Control register fields
`define CTL_PRBS1            15
`define CTL_PRBS2            14
`define CTL_PRBS3            13
`define CTL_PRBS4            12
`define CTL_PAT1_HI          11
`define CTL_PAT1_LO          9
`define CTL_PAT2_HI          8
`define CTL_PAT2_LO          6
`define CTL_ROUND            5
`define CTL_K_HI             4
`define CTL_K_LO             1
`define CTL_HPF_EN           0
`define P34_PAT3_HI          7
`define P34_PAT3_LO          5
`define P34_PAT4_HI          4
`define P34_PAT4_LO          2
// Misc register: independent select and inversion
`define MISC_IND_SEL         4
`define MISC_INV_LO          0
`define RST_CTRL             16'h0000
`define RST_P34              16'h0000
`define RST_MISC             16'h0000
`define RST_CUSTOM           14'h0000
// Pattern codes
`define PAT_NORMAL           3'h0
`define PAT_SYNC             3'h1
`define PAT_ALT              3'h2
`define PAT_CUSTOM           3'h3
`define PAT_ONES             3'h4
`define PAT_TOGGLE           3'h5
`define PAT_ZEROS            3'h6
`define PAT_RAMP             3'h7
`define PRBS_SEED            14'h0001
`endif

// File: verilog/lane_test_pattern_and_highpass.v
// Overview of operation
// [RULE_01] With independent select, a lane's random-sequence bit puts PRBS on that lane.
// [RULE_02] Lane 1 code from control bits 11:9, lane 2 from bits 8:6.
// [RULE_03] Lane 3 code from pattern register bits 7:5, lane 4 from 4:2.
// [RULE_04] Codes: normal, sync, alternate, custom, ones, toggle, zeros, ramp.
// [RULE_05] Rounding bit clear truncates filter output; set rounds it.
// [RULE_06] Filter: y = 2^k/(2^k+1) * (x - x_prev + y_prev).
// [RULE_07] Host programs exponent k only within 2 to 10.
// [RULE_08] Exponent shapes channels 1-4 only while filter enable is set.
// [RULE_09] Filter enable resets to 0, bypass; 1 inserts filter.
// [RULE_10] Data inversion affects only normal data, never test patterns.
// [RULE_11] Host writes zeros to unused bits of lane 3/4 register.
`timescale 1ns/1ps
`include "lane_test_pattern_regs.vh"
module lane_test_pattern_and_highpass (
	// APB
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// Converter samples, one per channel, same clock
	input  wire        sample_valid,
	input  wire [55:0] sample_data,
	// Output lane words
	output reg         lane_valid,
	output reg  [55:0] lane_data
);
	localparam W = 14;
	reg  [15:0] ctrl_r;
	reg  [15:0] p34_r;
	reg  [15:0] misc_r;
	reg  [13:0] custom_r;
	wire        acc = psel & penable;
	wire        wr  = acc & pwrite;
	wire        hit = (paddr == `ADDR_LANE_CTRL) | (paddr == `ADDR_LANE34_PAT) |
	                  (paddr == `ADDR_LANE_MISC) | (paddr == `ADDR_FILTER_STATUS);
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= `RST_CTRL; // RULE_09
			p34_r    <= `RST_P34;
			misc_r   <= `RST_MISC;
			custom_r <= `RST_CUSTOM;
		end else if (wr) begin
			case (paddr)
			`ADDR_LANE_CTRL:     ctrl_r <= pwdata[15:0];
			`ADDR_LANE34_PAT:    p34_r <= pwdata[15:0];
			`ADDR_LANE_MISC:     misc_r <= pwdata[15:0];
			`ADDR_FILTER_STATUS: custom_r <= pwdata[13:0];
			default:             ctrl_r <= ctrl_r;
			endcase
		end
	end
	// Free-running pattern state
	reg  [13:0] prbs_r;
	reg  [13:0] ramp_r;
	reg         tog_r;
	wire        ind = misc_r[`MISC_IND_SEL];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prbs_r <= `PRBS_SEED;
			ramp_r <= 14'h0000;
			tog_r  <= 1'b0;
		end else if (sample_valid) begin
			prbs_r <= {prbs_r[12:0], prbs_r[13] ^ prbs_r[12] ^ prbs_r[11] ^ prbs_r[1]};
			ramp_r <= ramp_r + 14'h0001;
			tog_r  <= ~tog_r;
		end
	end
	// High-pass filter per channel
	reg  [55:0] xprev_r;
	reg  [55:0] yprev_r;
	reg  [55:0] filt;
	reg  [55:0] yfull;
	reg  signed [W+11:0] s;
	reg  signed [W+11:0] prod;
	reg  signed [W+11:0] q;
	reg  signed [W+11:0] div;
	reg  [3:0]  k;
	integer     c;
	always @* begin
		filt  = sample_data;
		yfull = yprev_r;
		k     = ctrl_r[`CTL_K_HI:`CTL_K_LO];
		s     = 0;
		prod  = 0;
		q     = 0;
		// Signed divisor 2^k+1 keeps the quotient signed
		div   = 26'sd1 <<< k;
		div   = div + 26'sd1;
		for (c = 0; c < 4; c = c + 1) begin
			s = $signed({{12{sample_data[c*W+W-1]}}, sample_data[c*W +: W]})
			  - $signed({{12{xprev_r[c*W+W-1]}}, xprev_r[c*W +: W]})
			  + $signed({{12{yprev_r[c*W+W-1]}}, yprev_r[c*W +: W]}); // RULE_06
			prod = s <<< k; // RULE_08
			if (ctrl_r[`CTL_ROUND] && prod < 0)
				q = (prod - (div >>> 1)) / div; // RULE_05
			else if (ctrl_r[`CTL_ROUND])
				q = (prod + (div >>> 1)) / div; // RULE_05
			else
				q = prod / div; // RULE_05
			if (q > 26'sd8191)
				q = 26'sd8191;
			else if (q < -26'sd8192)
				q = -26'sd8192;
			yfull[c*W +: W] = q[W-1:0];
			if (ctrl_r[`CTL_HPF_EN])
				filt[c*W +: W] = q[W-1:0]; // RULE_09
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xprev_r <= 56'h0;
			yprev_r <= 56'h0;
		end else if (sample_valid) begin
			xprev_r <= sample_data;
			yprev_r <= ctrl_r[`CTL_HPF_EN] ? yfull : 56'h0;
		end
	end
	// Lane pattern mux
	reg  [2:0]  code;
	reg         prbs_en;
	reg  [55:0] out;
	reg  [13:0] w;
	integer     l;
	always @* begin
		out = filt;
		code = `PAT_NORMAL;
		prbs_en = 1'b0;
		w = 14'h0000;
		for (l = 0; l < 4; l = l + 1) begin
			case (l)
			0: code = ctrl_r[`CTL_PAT1_HI:`CTL_PAT1_LO]; // RULE_02
			1: code = ctrl_r[`CTL_PAT2_HI:`CTL_PAT2_LO]; // RULE_02
			2: code = p34_r[`P34_PAT3_HI:`P34_PAT3_LO]; // RULE_03
			default: code = p34_r[`P34_PAT4_HI:`P34_PAT4_LO]; // RULE_03
			endcase
			prbs_en = ctrl_r[`CTL_PRBS1 - l];
			if (!ind)
				code = `PAT_NORMAL;
			case (code) // RULE_04
			`PAT_SYNC:   w = 14'h3f80;
			`PAT_ALT:    w = tog_r ? 14'h3fff : 14'h0000;
			`PAT_CUSTOM: w = custom_r;
			`PAT_ONES:   w = 14'h3fff;
			`PAT_TOGGLE: w = tog_r ? 14'h2aaa : 14'h1555;
			`PAT_ZEROS:  w = 14'h0000;
			`PAT_RAMP:   w = ramp_r;
			default:     w = misc_r[`MISC_INV_LO + l] ? ~filt[l*W +: W] : filt[l*W +: W]; // RULE_10
			endcase
			if (ind && prbs_en)
				w = prbs_r; // RULE_01
			out[l*W +: W] = w;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_valid <= 1'b0;
			lane_data  <= 56'h0;
		end else begin
			lane_valid <= sample_valid;
			if (sample_valid)
				lane_data <= out;
		end
	end
	always @* begin
		case (paddr)
		`ADDR_LANE_CTRL:     prdata = {16'h0000, ctrl_r};
		`ADDR_LANE34_PAT:    prdata = {16'h0000, p34_r};
		`ADDR_LANE_MISC:     prdata = {16'h0000, misc_r};
		`ADDR_FILTER_STATUS: prdata = {18'h00000, custom_r};
		default:             prdata = 32'h00000000;
		endcase
	end
endmodule // lane_test_pattern_and_highpass

// File: verification/lane_chk_sva.sv
`timescale 1ns/1ps
module lane_chk (
	// APB
	input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	// Stream
	input wire sample_valid, lane_valid,
	input wire [55:0] sample_data, lane_data
);
	reg [15:0] c_r, p_r, m_r;
	wire sv = sample_valid & m_r[4];
	wire mapped = paddr == 12'h054 || paddr == 12'h05c || paddr == 12'h060 || paddr == 12'h064;
	// Shadow of the written settings
	always @(posedge pclk or negedge presetn)
		if (!presetn) begin
			c_r <= 16'h0;
			p_r <= 16'h0;
			m_r <= 16'h0;
		end else if (psel & penable & pwrite) begin
			if (paddr == 12'h054) c_r <= pwdata[15:0];
			if (paddr == 12'h05c) p_r <= pwdata[15:0];
			if (paddr == 12'h060) m_r <= pwdata[15:0];
		end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_valid_lag: assert property (lane_valid == $past(sample_valid)) else $error("valid lag");
	a_bypass_data: assert property (sample_valid && !c_r[0] && m_r == 16'h0
		|=> lane_data == $past(sample_data)) else $error("bypass data");
	a_lane1_ones: assert property (sv && c_r[11:9] == 3'h4 && !c_r[15]
		|=> lane_data[13:0] == 14'h3fff) else $error("lane1 code");
	a_lane2_zeros: assert property (sv && c_r[8:6] == 3'h6 && !c_r[14]
		|=> lane_data[27:14] == 14'h0) else $error("lane2 code");
	a_lane3_ones: assert property (sv && p_r[7:5] == 3'h4 && !c_r[13]
		|=> lane_data[41:28] == 14'h3fff) else $error("lane3 code");
	a_lane4_sync: assert property (sv && p_r[4:2] == 3'h1 && !c_r[12]
		|=> lane_data[55:42] == 14'h3f80) else $error("lane4 code");
	a_unmapped_err: assert property (psel && penable && !mapped
		|-> pslverr && prdata == 32'h0) else $error("unmapped");
	a_ready_high: assert property (psel && penable |-> pready) else $error("ready");
endmodule // lane_chk
bind lane_test_pattern_and_highpass lane_chk u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .sample_valid, .lane_valid,
	.sample_data, .lane_data);

// File: verification/lane_capture.sv
`timescale 1ns/1ps
module lane_capture (
	input wire pclk, lane_valid,
	input wire [55:0] lane_data,
	output reg [55:0] word_r
);
	initial word_r = 56'h0;
	always @(posedge pclk)
		if (lane_valid) word_r <= lane_data;
endmodule // lane_capture

// File: verification/tb_top.sv
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0, err;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd;
	reg [55:0] sample_data = 0;
	wire pready, pslverr, lane_valid;
	wire [31:0] prdata;
	wire [55:0] lane_data, w;
	int checks_done = 0, n_mismatch = 0;
	initial forever #20 pclk = ~pclk;
	lane_test_pattern_and_highpass dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .sample_valid, .sample_data, .lane_valid, .lane_data);
	lane_capture cap (.pclk, .lane_valid, .lane_data, .word_r(w));
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
		int i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			final_report;
		end
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task smp(input reg [55:0] d);
		@(posedge pclk);
		{sample_valid, sample_data} <= {1'b1, d};
		@(posedge pclk);
		sample_valid <= 0;
		@(posedge pclk);
		#1;
	endtask
	task t_regs;
		for (int i = 0; i < 4; i++) begin
			apb(0, 12'h054 + 12'(i == 0 ? 0 : i * 4 + 4), 0);
			`CK(rd, 32'h0)
		end
		apb(0, 12'h010, 0);
		`CK({err, rd}, 33'h100000000)
		apb(1, 12'h05c, 32'hfc);
		apb(0, 12'h05c, 0);
		`CK(rd, 32'hfc)
	endtask
	task t_codes;
		reg [13:0] e[8];
		e = '{14'h2dcb, 14'h3f80, 14'h0000, 14'h0abc, 14'h3fff, 14'h2aaa, 14'h0000, 14'h0007};
		apb(1, 12'h064, 32'h0abc);
		apb(1, 12'h060, 32'h1f);
		for (int c = 0; c < 8; c++) begin
			apb(1, 12'h054, 32'(c * 576));
			apb(1, 12'h05c, 32'(c * 36));
			smp({4{14'h1234}});
			`CK(w, {4{e[c]}})
		end
		apb(1, 12'h054, 32'h8800);
		smp(0);
		`CK(w[27:0] == {2{14'h3fff}}, 1'b0)
		`CK(w[13:0], 14'h0155)
		`CK(w[27:14], 14'h3fff)
	endtask
	task t_filter;
		apb(1, 12'h060, 0);
		apb(1, 12'h054, 0);
		smp({4{14'h1234}});
		`CK(w, {4{14'h1234}})
		smp(0);
		`CK(w, 56'h0)
		apb(1, 12'h054, 32'h5);
		smp(56'd101);
		`CK(w[13:0], 14'd80)
		smp(56'd101);
		`CK(w[13:0], 14'd64)
		apb(1, 12'h054, 0);
		smp(0);
		apb(1, 12'h054, 32'h25);
		smp(56'd101);
		`CK(w[13:0], 14'd81)
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_codes;
		t_filter;
		final_report;
	end
endmodule // tb_top
